// ===== rtl/prio_bank.sv
// bank of four interrupt priority words with decoded per-source levels
`timescale 1ns/10ps
// Functional notes
// - code 111 gives priority level 7
// - code 001 gives level 1, others matching
// - code 000 disables the source
// - word six bits 10:8 serial B receive
// - word six bits 6:4 external irq two
// - word eight bits 6:4 SPI B event
// - word eight bits 2:0 SPI B fault
// - word nine bits 14:12 capture ch5
// - word nine bits 10:8 capture ch4
// - word nine bits 6:4 capture ch3
module prio_bank (
   input  wire logic                                           i_clk,
   input  wire logic                                           i_rst_b,
   input  wire logic [prio_pkg::ADDR_W-1:0]                    i_addr,
   input  wire logic [prio_pkg::DATA_W-1:0]                    i_wdata,
   input  wire logic                                           i_wr,
   input  wire logic                                           i_rd,
   output logic      [prio_pkg::DATA_W-1:0]                    o_rdata,
   output logic      [prio_pkg::NUM_SRC*prio_pkg::FIELD_W-1:0] o_level,
   output logic      [prio_pkg::NUM_SRC-1:0]                   o_enable
);
   // level of the field whose low bit is at pos; the code is the level itself
   function automatic logic [prio_pkg::FIELD_W-1:0] field(
      input logic [prio_pkg::DATA_W-1:0] w,
      input int                          pos
   );
      field = w[pos +: prio_pkg::FIELD_W];
   endfunction

   // reset image: code 100 in every implemented field
   function automatic logic [prio_pkg::DATA_W-1:0] init_of(
      input logic [prio_pkg::DATA_W-1:0] mask
   );
      logic [prio_pkg::DATA_W-1:0] r;
      r = '0;
      for (int i = 0; i < prio_pkg::DATA_W; i += 4) begin
         if (mask[i +: prio_pkg::FIELD_W] != prio_pkg::PRIO_DISABLED) begin
            r[i +: prio_pkg::FIELD_W] = prio_pkg::PRIO_RESET;
         end
      end
      init_of = r;
   endfunction

   prio_word_if w5 ();
   prio_word_if w6 ();
   prio_word_if w8 ();
   prio_word_if w9 ();

   wire logic hit5 = i_addr == prio_pkg::OFS_WORD_FIVE;
   wire logic hit6 = i_addr == prio_pkg::OFS_WORD_SIX;
   wire logic hit8 = i_addr == prio_pkg::OFS_WORD_EIGHT;
   wire logic hit9 = i_addr == prio_pkg::OFS_WORD_NINE;

   assign w5.wr    = i_wr & hit5;
   assign w6.wr    = i_wr & hit6;
   assign w8.wr    = i_wr & hit8;
   assign w9.wr    = i_wr & hit9;
   assign w5.wdata = i_wdata;
   assign w6.wdata = i_wdata;
   assign w8.wdata = i_wdata;
   assign w9.wdata = i_wdata;

   // masking at the word keeps unused bits zero for every read path
   prio_word #(
      .MASK (prio_pkg::MASK_WORD_FIVE),
      .INIT (init_of(prio_pkg::MASK_WORD_FIVE))
   ) u_word_five (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .port    (w5.word)
   );
   prio_word #(
      .MASK (prio_pkg::MASK_WORD_SIX),
      .INIT (init_of(prio_pkg::MASK_WORD_SIX))
   ) u_word_six (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .port    (w6.word)
   );
   prio_word #(
      .MASK (prio_pkg::MASK_WORD_EIGHT),
      .INIT (init_of(prio_pkg::MASK_WORD_EIGHT))
   ) u_word_eight (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .port    (w8.word)
   );
   prio_word #(
      .MASK (prio_pkg::MASK_WORD_NINE),
      .INIT (init_of(prio_pkg::MASK_WORD_NINE))
   ) u_word_nine (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .port    (w9.word)
   );

   logic [prio_pkg::FIELD_W-1:0] lvl [prio_pkg::NUM_SRC];

   assign lvl[prio_pkg::SRC_TIMER_FOUR]  = field(w5.value, prio_pkg::POS_HIGH);
   assign lvl[prio_pkg::SRC_COMPARE_CH4] = field(w5.value, prio_pkg::POS_MID);
   assign lvl[prio_pkg::SRC_COMPARE_CH3] = field(w5.value, prio_pkg::POS_LOW);
   assign lvl[prio_pkg::SRC_SER_B_TX]    = field(w6.value, prio_pkg::POS_HIGH);
   assign lvl[prio_pkg::SRC_SER_B_RX]    = field(w6.value, prio_pkg::POS_MID);
   assign lvl[prio_pkg::SRC_EXT_TWO]     = field(w6.value, prio_pkg::POS_LOW);
   assign lvl[prio_pkg::SRC_TIMER_FIVE]  = field(w6.value, prio_pkg::POS_BASE);
   assign lvl[prio_pkg::SRC_SPI_B_EVENT] = field(w8.value, prio_pkg::POS_LOW);
   assign lvl[prio_pkg::SRC_SPI_B_FAULT] = field(w8.value, prio_pkg::POS_BASE);
   assign lvl[prio_pkg::SRC_CAPTURE_CH5] = field(w9.value, prio_pkg::POS_HIGH);
   assign lvl[prio_pkg::SRC_CAPTURE_CH4] = field(w9.value, prio_pkg::POS_MID);
   assign lvl[prio_pkg::SRC_CAPTURE_CH3] = field(w9.value, prio_pkg::POS_LOW);

   // flat level vector, 3 bits per source; level equals the code, 7 highest
   logic [prio_pkg::NUM_SRC*prio_pkg::FIELD_W-1:0] level_flat;
   logic [prio_pkg::NUM_SRC-1:0]                   en_flat;
   always_comb begin
      level_flat = '0;
      en_flat    = '0;
      for (int s = 0; s < prio_pkg::NUM_SRC; s++) begin
         level_flat[s*prio_pkg::FIELD_W +: prio_pkg::FIELD_W] = lvl[s];
         en_flat[s] = lvl[s] != prio_pkg::PRIO_DISABLED;
      end
   end

   // levels are straight from word flops; enable is the only gate added
   assign o_level  = level_flat;
   assign o_enable = en_flat;

   // read mux: decoded enable bits readable too, so software can see consumer view
   logic [prio_pkg::DATA_W-1:0] next_rdata;
   always_comb begin
      case (i_addr)
         prio_pkg::OFS_WORD_FIVE:  next_rdata = w5.value;
         prio_pkg::OFS_WORD_SIX:   next_rdata = w6.value;
         prio_pkg::OFS_WORD_EIGHT: next_rdata = w8.value;
         prio_pkg::OFS_WORD_NINE:  next_rdata = w9.value;
         prio_pkg::OFS_LEVELS_LO:  next_rdata = {4'h0, en_flat};
         prio_pkg::OFS_LEVELS_HI:  next_rdata = 16'h0000;
         default:                  next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= '0;
      end
   end
endmodule

// ===== common/prio_pkg.sv
// shared constants for the interrupt priority word bank
package prio_pkg;
   localparam int ADDR_W   = 4;
   localparam int DATA_W   = 16;
   localparam int FIELD_W  = 3;
   localparam int NUM_SRC  = 12;
   localparam int NUM_WORD = 4;

   // word offsets on the register port
   localparam logic [ADDR_W-1:0] OFS_WORD_FIVE  = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_WORD_SIX   = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_WORD_EIGHT = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_WORD_NINE  = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_LEVELS_LO  = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_LEVELS_HI  = 4'h5;

   // field low-bit positions
   localparam int POS_HIGH = 12;
   localparam int POS_MID  = 8;
   localparam int POS_LOW  = 4;
   localparam int POS_BASE = 0;

   // implemented-bit masks of each word
   localparam logic [DATA_W-1:0] MASK_WORD_FIVE  = 16'h7770;
   localparam logic [DATA_W-1:0] MASK_WORD_SIX   = 16'h7777;
   localparam logic [DATA_W-1:0] MASK_WORD_EIGHT = 16'h0077;
   localparam logic [DATA_W-1:0] MASK_WORD_NINE  = 16'h7770;

   localparam logic [FIELD_W-1:0] PRIO_RESET    = 3'h4;
   localparam logic [FIELD_W-1:0] PRIO_DISABLED = 3'h0;

   // source indices into the level vector
   localparam int SRC_TIMER_FOUR  = 0;
   localparam int SRC_COMPARE_CH4 = 1;
   localparam int SRC_COMPARE_CH3 = 2;
   localparam int SRC_SER_B_TX    = 3;
   localparam int SRC_SER_B_RX    = 4;
   localparam int SRC_EXT_TWO     = 5;
   localparam int SRC_TIMER_FIVE  = 6;
   localparam int SRC_SPI_B_EVENT = 7;
   localparam int SRC_SPI_B_FAULT = 8;
   localparam int SRC_CAPTURE_CH5 = 9;
   localparam int SRC_CAPTURE_CH4 = 10;
   localparam int SRC_CAPTURE_CH3 = 11;
endpackage

// ===== common/prio_word_if.sv
// write/read carrier between the bank and one priority word
`timescale 1ns/10ps
interface prio_word_if;
   logic                          wr;
   logic [prio_pkg::DATA_W-1:0]   wdata;
   logic [prio_pkg::DATA_W-1:0]   value;
   modport bank (output wr, output wdata, input value);
   modport word (input wr, input wdata, output value);
endinterface

// ===== rtl/prio_word.sv
// one masked priority word: unimplemented bits held at zero
`timescale 1ns/10ps
module prio_word #(
   parameter logic [prio_pkg::DATA_W-1:0] MASK = '0,
   parameter logic [prio_pkg::DATA_W-1:0] INIT = '0
) (
   input  wire logic     i_clk,
   input  wire logic     i_rst_b,
   prio_word_if.word     port
);
   logic [prio_pkg::DATA_W-1:0] value;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         value <= INIT;
      end else if (port.wr) begin
         value <= port.wdata & MASK;
      end
   end

   assign port.value = value;
endmodule

// ===== bench/prio_bank_properties.sv
// assertion checker for the priority word bank
`timescale 1ns/10ps
module prio_bank_properties (
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [15:0] o_rdata,
   input  wire logic [35:0] o_level,
   input  wire logic [11:0] o_enable
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   wire w_five  = i_wr && i_addr == 4'h0;
   wire w_six   = i_wr && i_addr == 4'h1;
   wire w_eight = i_wr && i_addr == 4'h2;
   wire w_nine  = i_wr && i_addr == 4'h3;
   AST_RESET: assert property ($rose(i_rst_b) |-> o_level == {12{3'h4}})
      else $error("levels not at reset code");
   AST_IDLE_RD: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
      else $error("read data outside read cycle");
   AST_EN: assert property (o_enable[5] == (o_level[17:15] != 3'h0))
      else $error("enable does not follow code");
   AST_W5: assert property (w_five |=> o_level[8:0] == {$past(i_wdata[6:4]),
      $past(i_wdata[10:8]), $past(i_wdata[14:12])}) else $error("word five placement");
   AST_W6RX: assert property (w_six |=> o_level[14:12] == $past(i_wdata[10:8]))
      else $error("serial b receive field");
   AST_W6EX: assert property (w_six |=> o_level[17:15] == $past(i_wdata[6:4]))
      else $error("ext irq two field");
   AST_W8EV: assert property (w_eight |=> o_level[23:21] == $past(i_wdata[6:4]))
      else $error("spi b event field");
   AST_W8FT: assert property (w_eight |=> o_level[26:24] == $past(i_wdata[2:0]))
      else $error("spi b fault field");
   AST_W9: assert property (w_nine |=> o_level[35:27] == {$past(i_wdata[6:4]),
      $past(i_wdata[10:8]), $past(i_wdata[14:12])}) else $error("word nine placement");
   AST_RD9: assert property (i_rd && i_addr == 4'h3 |=> (o_rdata & 16'h888f) == 16'h0)
      else $error("word nine unused bits");
   cover property (w_six && i_wdata[6:4] == 3'h0);
   cover property (i_rd && i_addr == 4'h3);
   cover property (w_eight ##1 i_rd);
endmodule
bind prio_bank prio_bank_properties i_prio_bank_properties (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_level(o_level), .o_enable(o_enable));

// ===== bench/test_prio_bank.sv
// self-checking bench for the priority word bank
`timescale 1ns/10ps
module test_prio_bank;
   localparam int          WI [12]  = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 3};
   localparam int          POS [12] = '{12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4};
   localparam logic [15:0] MSK [4]  = '{16'h7770, 16'h7777, 16'h0077, 16'h7770};
   localparam logic [15:0] RST [4]  = '{16'h4440, 16'h4444, 16'h0044, 16'h4440};
   logic        i_clk = 1'h0;
   logic        i_rst_b = 1'h0;
   logic [3:0]  i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0;
   logic        i_wr = 1'h0;
   logic        i_rd = 1'h0;
   logic        rd_q = 1'h0;
   logic [15:0] o_rdata;
   logic [35:0] o_level;
   logic [11:0] o_enable;
   logic [15:0] exp_w [4] = RST;
   logic [15:0] rq [$];
   logic [31:0] seed = 32'hce8e;
   int          error_cnt = 0;
   int          checks_done = 0;
   prio_bank i_prio_bank (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_level(o_level), .o_enable(o_enable));
   always #5 i_clk = ~i_clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [2:0] lvl(input int s);
      return exp_w[WI[s]][POS[s]+:3];
   endfunction
   function automatic logic [11:0] en_exp();
      for (int s = 0; s < 12; s++) en_exp[s] = lvl(s) != 3'h0;
   endfunction
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'h1) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   // strobes are only raised here and lowered by the other task or rst, one assignment a step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_wr <= 1'h1;
      i_rd <= 1'h0;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      if (a < 4'h4) exp_w[a[1:0]] = d & MSK[a[1:0]];
   endtask
   task automatic rd(input logic [3:0] a);
      i_rd <= 1'h1;
      i_wr <= 1'h0;
      i_addr <= a;
      @(posedge i_clk);
      rq.push_back(a < 4'h4 ? exp_w[a[1:0]] : a == 4'h4 ? {4'h0, en_exp()} : 16'h0);
   endtask
   // one idle edge first so a pending read answer is not wiped by the reset
   task automatic rst();
      i_wr <= 1'h0;
      i_rd <= 1'h0;
      @(posedge i_clk);
      i_rst_b <= 1'h0;
      exp_w = RST;
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'h1;
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge i_clk) rd_q <= i_rd;
   always @(negedge i_clk) begin
      if (rd_q) chk(o_rdata === rq.pop_front(), "read data");
      else chk(o_rdata === 16'h0, "idle read data");
      for (int s = 0; s < 12; s++) chk(o_level[3*s+:3] === lvl(s), "level");
      chk(o_enable === en_exp(), "enable");
   end
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'h1;
      for (int a = 0; a < 16; a++) rd(a[3:0]);
      for (int c = 0; c < 8; c++) begin
         wr(4'h1, {1'h0, c[2:0], 1'h1, c[2:0], 1'h0, c[2:0], 1'h1, ~c[2:0]});
         rd(4'h1);
         rd(4'h4);
      end
      for (int n = 0; n < 80; n++) begin
         seed = xs(seed);
         if (seed[0]) wr({1'h0, seed[10:8]}, seed[31:16]);
         else rd({1'h0, seed[10:8]});
      end
      for (int a = 0; a < 5; a++) wr(a[3:0], 16'hffff);
      for (int a = 0; a < 5; a++) rd(a[3:0]);
      rst();
      for (int a = 0; a < 6; a++) rd(a[3:0]);
      rst();
      summarize();
   end
endmodule
